//--- design/fcr_pkg.sv
/*
 * Package for the flash control register block: register offsets, field
 * positions, reset values and key codes.
 * Assumes a single 50 MHz clock domain and an Avalon-MM register bus.
 */
package fcr_pkg;
  // ==========================================================
  // Register indices (printed offsets; byte address is index times four)
  localparam logic [15:0] IDX_POLICY_STAGING = 16'h0fd0;
  localparam logic [15:0] IDX_COMMIT_KEY = 16'h0fd1;
  localparam logic [15:0] IDX_SLEEP_CTRL = 16'h0fd2;
  localparam logic [15:0] IDX_PIN_GATE = 16'h0fd3;
  localparam int ADDR_W = 18;
  localparam logic [ADDR_W-1:0] ADDR_POLICY_STAGING = {IDX_POLICY_STAGING, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_COMMIT_KEY = {IDX_COMMIT_KEY, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SLEEP_CTRL = {IDX_SLEEP_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PIN_GATE = {IDX_PIN_GATE, 2'b00};
  // ==========================================================
  // Field positions
  localparam int PERMIT_MSB = 7;
  localparam int PERMIT_LSB = 5;
  localparam int BOOT_BIT = 4;
  localparam int AREA_MSB = 3;
  localparam int AREA_LSB = 2;
  localparam int ROMSEL_MSB = 1;
  localparam int ROMSEL_LSB = 0;
  localparam int MON_PERMIT_BIT = 5;
  localparam int SLEEP_BIT = 0;
  localparam int GATE_SCLK_BIT = 1;
  localparam int GATE_GEN_BIT = 0;
  // ==========================================================
  // Codes and reset values
  localparam logic [2:0] PERMIT_DISABLE = 3'h2;
  localparam logic [2:0] PERMIT_ENABLE = 3'h5;
  localparam logic [1:0] AREA_STANDARD = 2'h0;
  localparam logic [1:0] AREA_CODE_TO_DATA = 2'h2;
  localparam logic [7:0] COMMIT_KEY_CODE = 8'hd5;
  localparam logic [7:0] STAGING_RESET = 8'h40;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : fcr_pkg

//--- design/fcr_flash_ctrl.sv
/*
 * Flash control register block: staged policy register with key commit,
 * applied-configuration monitor, flash sleep control and pin input gates.
 * Assumes inputs synchronous to clk_i and an Avalon-MM master that holds
 * each request until waitrequest is seen low.
 */
// Register access over Avalon-MM was decided locally.
`timescale 1ns/100ps
module fcr_flash_ctrl
  import fcr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Mode and CPU context
  input wire logic serial_mode_i,
  input wire logic fetch_from_ram_i,
  input wire logic flash_access_i,
  input wire logic flash_cmd_i,
  // Flash array side
  output logic flash_cmd_o,
  output logic flash_active_o,
  output logic standby_reset_o,
  output logic boot_rom_overlay_o,
  output logic [1:0] area_map_o,
  output logic [1:0] rom_select_o,
  // Port input gating
  output logic serial_clock_input_en_o,
  output logic general_input_en_o
);

  // ==========================================================
  // Bus decode
  // One wait cycle per access keeps read data registered.
  logic ack;
  logic req;
  logic wr_lane0;
  logic [7:0] wdata;
  logic hit_staging;
  logic hit_key;
  logic hit_sleep;
  logic hit_gate;

  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack;
  assign wr_lane0 = avs_write_i & ack & avs_byteenable_i[0];
  assign wdata = avs_writedata_i[7:0];
  assign hit_staging = (avs_address_i == ADDR_POLICY_STAGING);
  assign hit_key = (avs_address_i == ADDR_COMMIT_KEY);
  assign hit_sleep = (avs_address_i == ADDR_SLEEP_CTRL);
  assign hit_gate = (avs_address_i == ADDR_PIN_GATE);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // ==========================================================
  // Staging and applied registers
  logic [7:0] flash_policy_staging;
  logic [7:0] applied;
  logic commit;

  assign commit = wr_lane0 & hit_key & (wdata == COMMIT_KEY_CODE);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flash_policy_staging <= STAGING_RESET;
    end else if (wr_lane0 && hit_staging) begin
      flash_policy_staging <= wdata;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      applied <= STAGING_RESET;
    end else if (commit) begin
      applied <= flash_policy_staging;
    end
  end

  // ==========================================================
  // Applied configuration decode
  logic permit_applied_bit;
  logic boot_overlay_applied;
  logic [1:0] area_map_applied;
  logic [1:0] rom_select_applied;
  logic [7:0] applied_config_monitor;

  // Only the exact enable code counts; reserved codes stay disabled.
  assign permit_applied_bit = (applied[PERMIT_MSB:PERMIT_LSB] == PERMIT_ENABLE);
  assign boot_overlay_applied = serial_mode_i | applied[BOOT_BIT];
  // Reserved 01 falls back to standard mapping.
  assign area_map_applied = (applied[AREA_MSB:AREA_LSB] == AREA_CODE_TO_DATA) ?
    AREA_CODE_TO_DATA : AREA_STANDARD;
  assign rom_select_applied = applied[ROMSEL_MSB:ROMSEL_LSB];

  always_comb begin
    applied_config_monitor = ZERO_BYTE;
    applied_config_monitor[MON_PERMIT_BIT] = permit_applied_bit;
    applied_config_monitor[BOOT_BIT] = boot_overlay_applied;
    applied_config_monitor[AREA_MSB:AREA_LSB] = applied[AREA_MSB:AREA_LSB];
    applied_config_monitor[ROMSEL_MSB:ROMSEL_LSB] = rom_select_applied;
  end

  // ==========================================================
  // Flash array controls
  logic staged_enable;

  // Judged at commit time, so a later staging write cannot wake the array without a fresh key.
  assign staged_enable = (flash_policy_staging[PERMIT_MSB:PERMIT_LSB] == PERMIT_ENABLE);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flash_active_o <= 1'b0;
    end else if (commit) begin
      flash_active_o <= staged_enable;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_rom_overlay_o <= 1'b0;
    end else begin
      boot_rom_overlay_o <= boot_overlay_applied;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      area_map_o <= AREA_STANDARD;
    end else begin
      area_map_o <= area_map_applied;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rom_select_o <= 2'h0;
    end else begin
      rom_select_o <= rom_select_applied;
    end
  end

  // Gated every cycle by the applied permit code, so a command still held when the permit is withdrawn is cut off.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flash_cmd_o <= 1'b0;
    end else begin
      flash_cmd_o <= flash_cmd_i & permit_applied_bit;
    end
  end

  // ==========================================================
  // Flash sleep control
  logic flash_sleep_bit;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flash_sleep_bit <= 1'b0;
    end else if (wr_lane0 && hit_sleep && fetch_from_ram_i) begin
      flash_sleep_bit <= wdata[SLEEP_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      standby_reset_o <= 1'b0;
    end else begin
      standby_reset_o <= flash_sleep_bit & flash_access_i;
    end
  end

  // ==========================================================
  // Pin input gate
  logic serial_clock_input_gate;
  logic general_input_gate;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_clock_input_gate <= 1'b0;
      general_input_gate <= 1'b0;
    end else if (wr_lane0 && hit_gate && serial_mode_i) begin
      serial_clock_input_gate <= wdata[GATE_SCLK_BIT];
      general_input_gate <= wdata[GATE_GEN_BIT];
    end
  end

  // Normal mode keeps every input open regardless of stored gates.
  assign serial_clock_input_en_o = ~serial_mode_i | serial_clock_input_gate;
  assign general_input_en_o = ~serial_mode_i | general_input_gate;

  // ==========================================================
  // Read data
  logic read_take;
  logic [7:0] next_read_byte;

  // Captured in the first cycle of a read and then held, so the master sees a settled value.
  assign read_take = avs_read_i & ~ack;

  always_comb begin
    next_read_byte = ZERO_BYTE;
    if (hit_staging) begin
      next_read_byte = flash_policy_staging;
    end else if (hit_key) begin
      next_read_byte = applied_config_monitor;
    end else if (hit_sleep) begin
      next_read_byte = ZERO_BYTE;
    end else if (hit_gate && serial_mode_i) begin
      next_read_byte[GATE_SCLK_BIT] = serial_clock_input_gate;
      next_read_byte[GATE_GEN_BIT] = general_input_gate;
    end else begin
      next_read_byte = ZERO_BYTE;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= UNMAPPED_READ;
    end else if (read_take) begin
      avs_readdata_o <= {24'h00_0000, next_read_byte};
    end
  end

endmodule : fcr_flash_ctrl

//--- tb/fcr_checker.sv
/* Port checker for fcr_flash_ctrl.
   Assumes one clock and the bind below. */
`timescale 1ns/100ps
module fcr_checker
  import fcr_pkg::*;
(
  // Clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Context and flash side
  input wire logic serial_mode_i,
  input wire logic flash_access_i,
  input wire logic flash_cmd_i,
  input wire logic flash_cmd_o,
  input wire logic flash_active_o,
  input wire logic standby_reset_o,
  input wire logic boot_rom_overlay_o,
  input wire logic [1:0] area_map_o,
  input wire logic serial_clock_input_en_o,
  input wire logic general_input_en_o
);
  // ==========================================
  // Assertions
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rdn;
  logic cmt;
  assign rdn = avs_read_i && !avs_waitrequest_o;
  assign cmt = avs_write_i && !avs_waitrequest_o && avs_address_i == ADDR_COMMIT_KEY
    && avs_writedata_i[7:0] == COMMIT_KEY_CODE;
  a_gate_normal_on: assert property (!serial_mode_i |-> serial_clock_input_en_o && general_input_en_o)
    else $error("input gate off in normal mode");
  a_cmd_gated: assert property (flash_cmd_o |-> $past(flash_cmd_i) && $past(flash_active_o))
    else $error("command passed while disabled");
  a_standby_cause: assert property (standby_reset_o |-> $past(flash_access_i))
    else $error("standby reset without access");
  a_boot_serial: assert property (serial_mode_i && $past(serial_mode_i) |-> boot_rom_overlay_o)
    else $error("boot overlay hidden in serial mode");
  a_area_commit: assert property ($changed(area_map_o) |-> $past(cmt) || $past(cmt, 2))
    else $error("area map moved without commit");
  a_active_commit: assert property ($changed(flash_active_o) |-> $past(cmt) || $past(cmt, 2))
    else $error("active state moved without commit");
  a_sleep_reads_zero: assert property (rdn && avs_address_i == ADDR_SLEEP_CTRL |-> avs_readdata_o == 32'h0)
    else $error("sleep register read nonzero");
  a_monitor_top_zero: assert property (rdn && avs_address_i == ADDR_COMMIT_KEY |-> avs_readdata_o[7:6] == 2'h0)
    else $error("monitor top bits set");
  a_gate_read_zero: assert property (rdn && avs_address_i == ADDR_PIN_GATE && !serial_mode_i
    |-> avs_readdata_o == 32'h0)
    else $error("gate read nonzero in normal mode");
endmodule : fcr_checker
bind fcr_flash_ctrl fcr_checker i_chk (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .serial_mode_i, .flash_access_i, .flash_cmd_i,
  .flash_cmd_o, .flash_active_o, .standby_reset_o, .boot_rom_overlay_o, .area_map_o,
  .serial_clock_input_en_o, .general_input_en_o);

//--- tb/fcr_flash_model.sv
/* Flash array beside the block: counts commands and standby resets.
   Assumes the block's clock and reset. */
`timescale 1ns/100ps
module fcr_flash_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // From the block
  input wire logic cmd_i,
  input wire logic standby_reset_i,
  // Counts
  output int cmd_count_o,
  output int reset_count_o
);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_count_o <= 0;
      reset_count_o <= 0;
    end else begin
      cmd_count_o <= cmd_count_o + int'(cmd_i);
      reset_count_o <= reset_count_o + int'(standby_reset_i);
    end
  end
endmodule : fcr_flash_model

//--- tb/tb_top.sv
/* Self-checking bench for fcr_flash_ctrl.
   Assumes the checker bind and the flash model. */
`timescale 1ns/100ps
module tb_top
  import fcr_pkg::*;
;
  // ==========================================
  // Signals
  logic clk_i = 0, rst_i = 1, rd_s = 0, wr_s = 0, ser = 0, ram = 0, wq, cmd_o, act, srst, boot, sck, gen;
  logic [1:0] stb = 2'h0, area, rsel;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0, rdo, rdata;
  int bad_count = 0, checked = 0, cmds, resets;
  always #10 clk_i = ~clk_i;
  fcr_flash_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(addr), .avs_read_i(rd_s),
    .avs_write_i(wr_s), .avs_byteenable_i(4'h1), .avs_writedata_i(wdata), .avs_readdata_o(rdo),
    .avs_waitrequest_o(wq), .serial_mode_i(ser), .fetch_from_ram_i(ram), .flash_access_i(stb[1]),
    .flash_cmd_i(stb[0]), .flash_cmd_o(cmd_o), .flash_active_o(act), .standby_reset_o(srst),
    .boot_rom_overlay_o(boot), .area_map_o(area), .rom_select_o(rsel), .serial_clock_input_en_o(sck),
    .general_input_en_o(gen));
  fcr_flash_model i_model (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd_o), .standby_reset_i(srst),
    .cmd_count_o(cmds), .reset_count_o(resets));
  // ==========================================
  // Tasks
  task check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  // Request stands until waitrequest is seen low at a rising edge; data is taken at that edge
  task xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    rd_s <= !w;
    wr_s <= w;
    addr <= a;
    wdata <= {24'h0, d};
    @(posedge clk_i);
    while (wq !== 1'b0) @(posedge clk_i);
    rdata = rdo;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask : xfer
  task rdc(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    check(rdata[7:0], exp);
  endtask : rdc
  task cfg(input logic [7:0] stage, input logic [7:0] mon);
    xfer(1'b1, ADDR_POLICY_STAGING, stage);
    xfer(1'b1, ADDR_COMMIT_KEY, COMMIT_KEY_CODE);
    rdc(ADDR_COMMIT_KEY, mon);
  endtask : cfg
  task pulse(input logic [1:0] s);
    @(posedge clk_i) stb <= s;
    @(posedge clk_i) stb <= 2'h0;
    repeat (3) @(posedge clk_i);
  endtask : pulse
  task give_verdict;
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // ==========================================
  // Tests
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(ADDR_POLICY_STAGING, STAGING_RESET);
    rdc(ADDR_COMMIT_KEY, ZERO_BYTE);
    rdc(18'h0, ZERO_BYTE);
    pulse(2'h1);
    check(8'(cmds), 8'h00);
    xfer(1'b1, ADDR_POLICY_STAGING, 8'ha8);
    rdc(ADDR_COMMIT_KEY, 8'h00);
    xfer(1'b1, ADDR_COMMIT_KEY, 8'h33);
    rdc(ADDR_COMMIT_KEY, 8'h00);
    xfer(1'b1, ADDR_COMMIT_KEY, COMMIT_KEY_CODE);
    rdc(ADDR_COMMIT_KEY, 8'h28);
    check({6'h0, area}, {6'h0, AREA_CODE_TO_DATA});
    check({7'h0, act}, 8'h01);
    pulse(2'h1);
    check(8'(cmds), 8'h01);
    cfg(8'h50, 8'h10);
    check({7'h0, boot}, 8'h01);
    check({7'h0, act}, 8'h00);
    cfg(8'h43, 8'h03);
    check({6'h0, rsel}, 8'h03);
    cfg(8'h40, 8'h00);
    check({6'h0, boot, act}, 8'h00);
    @(posedge clk_i) ser <= 1'b1;
    rdc(ADDR_COMMIT_KEY, 8'h10);
    check({7'h0, boot}, 8'h01);
    for (int i = 1; i < 3; i++) begin
      xfer(1'b1, ADDR_PIN_GATE, 8'(i));
      rdc(ADDR_PIN_GATE, 8'(i));
      check({6'h0, sck, gen}, 8'(i));
    end
    @(posedge clk_i) ser <= 1'b0;
    xfer(1'b1, ADDR_PIN_GATE, 8'h00);
    rdc(ADDR_PIN_GATE, 8'h00);
    check({6'h0, sck, gen}, 8'h03);
    xfer(1'b1, ADDR_SLEEP_CTRL, 8'h01);
    pulse(2'h2);
    check(8'(resets), 8'h00);
    @(posedge clk_i) ram <= 1'b1;
    xfer(1'b1, ADDR_SLEEP_CTRL, 8'h01);
    rdc(ADDR_SLEEP_CTRL, 8'h00);
    pulse(2'h2);
    check(8'(resets), 8'h01);
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    bad_count++;
    give_verdict;
  end
endmodule : tb_top
